// ### design/pwm_out_ctrl.sv
// Purpose: output control of a two-channel pwm timer with apb registers
// Assumes: one clock pclk at 100 MHz, async active-low presetn
// Notes:   a0/c0 carry the normal phase, b0/d0 the counter phase
//
// Functional notes
// R1: counter-phase level bit 0: idle high, active low; 1: the reverse
// R2: normal-phase level bit 0: idle high, active low; 1: the reverse
// R3: level bits act only in reset-synchronous and complementary modes
// R4: level bits ignored in timer and single-output pwm mode
// R5: software writes mode 00 for timer or single-output pwm
// R6: software writes mode 01 for reset-synchronous pwm
// R7: one complementary mode loads buffer into general on channel 1 underflow
// R8: other complementary mode loads buffer on channel 0 period match
// R9: cutoff bits 7:6 pick a0 state: off, high-z, low, high
// R10: cutoff bits 5:4 pick b0 state with the same codes
// R11: cutoff bits 3:2 pick c0 state with the same codes
// R12: software keeps unused pin fields 00 and edits only while stopped
// R13: cutoff bits 1:0 pick d0 state with the same codes
// R14: software keeps the sync bit 0 in complementary mode
// R15: each count-start flag stops its counter at 0, runs it at 1
// R16: active cutoff event with nonzero field overrides the pin waveform
// R17: software writes 0 to bits 5:4 and uses no unlisted mode codes
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ns

module pwm_out_ctrl #(
  parameter int CNT_W = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             cutoff_event,
  output logic                  out_pin_a0,
  output logic                  out_pin_a0_oe,
  output logic                  out_pin_b0,
  output logic                  out_pin_b0_oe,
  output logic                  out_pin_c0,
  output logic                  out_pin_c0_oe,
  output logic                  out_pin_d0,
  output logic                  out_pin_d0_oe
);

  // ******************************************************************
  // register state
  // ******************************************************************
  logic [7:0]       timer_function_control_reg;
  logic [7:0]       timer_function_control_next;
  logic [7:0]       channel0_pin_cutoff_select_reg;
  logic [7:0]       channel0_pin_cutoff_select_next;
  logic [2:0]       start_reg;
  logic [2:0]       start_next;
  logic [CNT_W-1:0] channel0_period_compare_reg;
  logic [CNT_W-1:0] channel0_period_compare_next;
  logic [CNT_W-1:0] buffer_reg;
  logic [CNT_W-1:0] buffer_next;
  logic [CNT_W-1:0] general_reg;
  logic [CNT_W-1:0] general_next;
  logic [CNT_W-1:0] channel0_counter_reg;
  logic [CNT_W-1:0] channel0_counter_next;
  logic [CNT_W-1:0] channel1_counter_reg;
  logic [CNT_W-1:0] channel1_counter_next;
  logic [31:0]      prdata_reg;
  logic [31:0]      prdata_next;
  logic [3:0]       pin_out_reg;
  logic [3:0]       pin_out_next;
  logic [3:0]       pin_oe_reg;
  logic [3:0]       pin_oe_next;

  logic             wr_en;
  logic             rd_en;
  logic             addr_hit;
  logic             match0;
  logic             uflow1;
  logic             running;
  logic             active;
  logic             levels_on;

  // ******************************************************************
  // helpers
  // ******************************************************************
  // pick the two cutoff bits of one pin; a0 owns the top pair
  function automatic logic [1:0] cut_field(input logic [7:0] df,
                                           input int         pin);
    cut_field = df[7 - 2*pin -: 2];
  endfunction

  // level-select polarity: 0 idles high and pulses low, 1 the reverse
  function automatic logic drive_level(input logic act, input logic sel);
    drive_level = ~(act ^ sel);
  endfunction

  // ******************************************************************
  // apb slave: zero wait states, unmapped addresses answer an error
  // ******************************************************************
  assign addr_hit = (paddr == pwm_out_pkg::OFS_FUNC_CTRL) ||
                    (paddr == pwm_out_pkg::OFS_CUTOFF0)   ||
                    (paddr == pwm_out_pkg::OFS_START)     ||
                    (paddr == pwm_out_pkg::OFS_PERIOD)    ||
                    (paddr == pwm_out_pkg::OFS_BUFFER)    ||
                    (paddr == pwm_out_pkg::OFS_STATUS);
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata  = prdata_reg;

  // ******************************************************************
  // counter events and mode decode
  // ******************************************************************
  assign match0  = start_reg[pwm_out_pkg::ST_START0] &&
                   (channel0_counter_reg == channel0_period_compare_reg);
  assign uflow1  = start_reg[pwm_out_pkg::ST_START1] &&
                   (channel1_counter_reg == '0);
  assign running = start_reg[pwm_out_pkg::ST_START0];
  assign active  = running && (channel0_counter_reg < general_reg);
  // timer mode leaves the level bits out of the picture
  assign levels_on = (timer_function_control_reg[1:0] !=
                      pwm_out_pkg::MODE_TIMER);                 // R3 R4

  // next values of registers and counters
  always_comb begin
    timer_function_control_next     = timer_function_control_reg;
    channel0_pin_cutoff_select_next = channel0_pin_cutoff_select_reg;
    start_next                      = start_reg;
    channel0_period_compare_next    = channel0_period_compare_reg;
    buffer_next                     = buffer_reg;
    general_next                    = general_reg;
    channel0_counter_next           = channel0_counter_reg;
    channel1_counter_next           = channel1_counter_reg;
    prdata_next                     = prdata_reg;
    if (wr_en) begin
      unique case (paddr)
        pwm_out_pkg::OFS_FUNC_CTRL: timer_function_control_next =
          pwdata[7:0] & pwm_out_pkg::FC_WRITE_MASK;
        pwm_out_pkg::OFS_CUTOFF0: channel0_pin_cutoff_select_next =
          pwdata[7:0];
        pwm_out_pkg::OFS_START:  start_next = pwdata[2:0];
        pwm_out_pkg::OFS_PERIOD: channel0_period_compare_next =
          pwdata[CNT_W-1:0];
        pwm_out_pkg::OFS_BUFFER: buffer_next = pwdata[CNT_W-1:0];
        default: ;
      endcase
    end
    if (rd_en) begin
      prdata_next = '0;
      unique case (paddr)
        pwm_out_pkg::OFS_FUNC_CTRL:
          prdata_next[7:0] = timer_function_control_reg;
        pwm_out_pkg::OFS_CUTOFF0:
          prdata_next[7:0] = channel0_pin_cutoff_select_reg;
        pwm_out_pkg::OFS_START:  prdata_next[2:0] = start_reg;
        pwm_out_pkg::OFS_PERIOD:
          prdata_next[CNT_W-1:0] = channel0_period_compare_reg;
        pwm_out_pkg::OFS_BUFFER: prdata_next[CNT_W-1:0] = buffer_reg;
        pwm_out_pkg::OFS_STATUS: begin
          prdata_next[CNT_W-1:0] = general_reg;
          prdata_next[pwm_out_pkg::STAT_CUT_BIT] = cutoff_event;
        end
        default: ;
      endcase
    end
    // channel 0 counts up to its period, channel 1 down to zero
    if (!start_reg[pwm_out_pkg::ST_START0] || match0)             // R15
      channel0_counter_next = '0;
    else
      channel0_counter_next = channel0_counter_reg + 1'b1;
    if (!start_reg[pwm_out_pkg::ST_START1] || uflow1)             // R15
      channel1_counter_next = channel0_period_compare_reg;
    else
      channel1_counter_next = channel1_counter_reg - 1'b1;
    // complementary modes only load the duty at a safe point
    unique case (timer_function_control_reg[1:0])
      pwm_out_pkg::MODE_COMP_UFL:
        if (uflow1) general_next = buffer_reg;                    // R7
      pwm_out_pkg::MODE_COMP_MAT:
        if (match0) general_next = buffer_reg;                    // R8
      default: general_next = buffer_reg;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_function_control_reg     <= pwm_out_pkg::FC_RESET;
      channel0_pin_cutoff_select_reg <= pwm_out_pkg::DF_RESET;
      start_reg                      <= pwm_out_pkg::ST_RESET;
      channel0_period_compare_reg    <= '0;
      buffer_reg                     <= '0;
      general_reg                    <= '0;
      channel0_counter_reg           <= '0;
      channel1_counter_reg           <= '0;
      prdata_reg                     <= '0;
    end else begin
      timer_function_control_reg     <= timer_function_control_next;
      channel0_pin_cutoff_select_reg <= channel0_pin_cutoff_select_next;
      start_reg                      <= start_next;
      channel0_period_compare_reg    <= channel0_period_compare_next;
      buffer_reg                     <= buffer_next;
      general_reg                    <= general_next;
      channel0_counter_reg           <= channel0_counter_next;
      channel1_counter_reg           <= channel1_counter_next;
      prdata_reg                     <= prdata_next;
    end
  end

  // ******************************************************************
  // pin drive: waveform, polarity, then forced cutoff on top
  // ******************************************************************
  // cutoff is checked last so a fault wins over the waveform on every pin whose cutoff field is nonzero
  always_comb begin
    logic       norm;
    logic       cntr;
    logic [1:0] f;
    norm = 1'b0;
    cntr = 1'b0;
    f    = 2'b00;
    if (levels_on) begin
      norm = drive_level(active, timer_function_control_reg
                         [pwm_out_pkg::FC_NORM_LVL]);             // R2
      cntr = drive_level(running && !active, timer_function_control_reg
                         [pwm_out_pkg::FC_CNTR_LVL]);             // R1
    end else begin
      norm = active;                                              // R4
      cntr = running && !active;
    end
    pin_out_next = {cntr, norm, cntr, norm};
    pin_oe_next  = 4'hF;
    for (int i = 0; i < pwm_out_pkg::NPINS; i++) begin
      f = cut_field(channel0_pin_cutoff_select_reg, i);    // R9 R10 R11 R13
      if (cutoff_event) begin
        unique case (f)                                           // R16
          pwm_out_pkg::CUT_HIZ:  pin_oe_next[i]  = 1'b0;
          pwm_out_pkg::CUT_LOW:  pin_out_next[i] = 1'b0;
          pwm_out_pkg::CUT_HIGH: pin_out_next[i] = 1'b1;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_reg <= 4'h0;
      pin_oe_reg  <= 4'hF;
    end else begin
      pin_out_reg <= pin_out_next;
      pin_oe_reg  <= pin_oe_next;
    end
  end

  assign out_pin_a0    = pin_out_reg[pwm_out_pkg::PIN_A0];
  assign out_pin_b0    = pin_out_reg[pwm_out_pkg::PIN_B0];
  assign out_pin_c0    = pin_out_reg[pwm_out_pkg::PIN_C0];
  assign out_pin_d0    = pin_out_reg[pwm_out_pkg::PIN_D0];
  assign out_pin_a0_oe = pin_oe_reg[pwm_out_pkg::PIN_A0];
  assign out_pin_b0_oe = pin_oe_reg[pwm_out_pkg::PIN_B0];
  assign out_pin_c0_oe = pin_oe_reg[pwm_out_pkg::PIN_C0];
  assign out_pin_d0_oe = pin_oe_reg[pwm_out_pkg::PIN_D0];

  // ******************************************************************
  // assertions
  // ******************************************************************
  property p_norm_level;
    @(posedge pclk) disable iff (!presetn)
    (levels_on && !running && !cutoff_event) |=> out_pin_a0 ==
      !$past(timer_function_control_reg[pwm_out_pkg::FC_NORM_LVL]);
  endproperty
  a_norm_level: assert property (p_norm_level)                    // R2
    else $error("normal phase idle level wrong");
  property p_cntr_level;
    @(posedge pclk) disable iff (!presetn)
    (levels_on && !running && !cutoff_event) |=> out_pin_b0 ==
      !$past(timer_function_control_reg[pwm_out_pkg::FC_CNTR_LVL]);
  endproperty
  a_cntr_level: assert property (p_cntr_level)                    // R1
    else $error("counter phase idle level wrong");
  property p_timer_ignores_level;
    @(posedge pclk) disable iff (!presetn)
    (!levels_on && !running && !cutoff_event) |=>
      (out_pin_a0 == 1'b0 && out_pin_b0 == 1'b0);
  endproperty
  a_timer_ignores_level: assert property (p_timer_ignores_level)  // R4
    else $error("level bits acted in timer mode");
  property p_load_uflow;
    @(posedge pclk) disable iff (!presetn)
    (timer_function_control_reg[1:0] == pwm_out_pkg::MODE_COMP_UFL &&
     !uflow1) |=> general_reg == $past(general_reg);
  endproperty
  a_load_uflow: assert property (p_load_uflow)                    // R7
    else $error("general loaded outside underflow");
  property p_load_match;
    @(posedge pclk) disable iff (!presetn)
    (timer_function_control_reg[1:0] == pwm_out_pkg::MODE_COMP_MAT &&
     match0) |=> general_reg == $past(buffer_reg);
  endproperty
  a_load_match: assert property (p_load_match)                    // R8
    else $error("general not loaded at match");
  property p_stop;
    @(posedge pclk) disable iff (!presetn)
    (!start_reg[pwm_out_pkg::ST_START0]) [*2] |-> channel0_counter_reg == '0;
  endproperty
  a_stop: assert property (p_stop)                                // R15
    else $error("counter 0 moved while stopped");
  property p_cut_hiz_a;
    @(posedge pclk) disable iff (!presetn)
    (cutoff_event && channel0_pin_cutoff_select_reg[7:6] ==
     pwm_out_pkg::CUT_HIZ) |=> !out_pin_a0_oe;
  endproperty
  a_cut_hiz_a: assert property (p_cut_hiz_a)                      // R9
    else $error("a0 not released on cutoff");
  property p_cut_low_b;
    @(posedge pclk) disable iff (!presetn)
    (cutoff_event && channel0_pin_cutoff_select_reg[5:4] ==
     pwm_out_pkg::CUT_LOW) |=> (!out_pin_b0 && out_pin_b0_oe);
  endproperty
  a_cut_low_b: assert property (p_cut_low_b)                      // R10
    else $error("b0 not low on cutoff");
  property p_cut_high_c;
    @(posedge pclk) disable iff (!presetn)
    (cutoff_event && channel0_pin_cutoff_select_reg[3:2] ==
     pwm_out_pkg::CUT_HIGH) |=> (out_pin_c0 && out_pin_c0_oe);
  endproperty
  a_cut_high_c: assert property (p_cut_high_c)                    // R11
    else $error("c0 not high on cutoff");
  property p_cut_off_d;
    @(posedge pclk) disable iff (!presetn)
    (channel0_pin_cutoff_select_reg[1:0] == pwm_out_pkg::CUT_OFF) |=>
      out_pin_d0_oe;
  endproperty
  a_cut_off_d: assert property (p_cut_off_d)                      // R13 R16
    else $error("d0 released with cutoff disabled");

endmodule

// ### design/pwm_out_pkg.sv
// Purpose: shared constants for the complementary pwm output control block
// Assumes: 32-bit apb, one word per register
// Notes:   offsets, field positions, mode and cutoff codes, reset values
package pwm_out_pkg;

  // ******************************************************************
  // register byte offsets
  // ******************************************************************
  localparam logic [7:0] OFS_FUNC_CTRL = 8'h00;
  localparam logic [7:0] OFS_CUTOFF0   = 8'h04;
  localparam logic [7:0] OFS_START     = 8'h08;
  localparam logic [7:0] OFS_PERIOD    = 8'h0C;
  localparam logic [7:0] OFS_BUFFER    = 8'h10;
  localparam logic [7:0] OFS_STATUS    = 8'h14;

  // ******************************************************************
  // function control fields
  // ******************************************************************
  localparam int         FC_MODE_LO     = 0;
  localparam int         FC_NORM_LVL    = 2;
  localparam int         FC_CNTR_LVL    = 3;
  localparam logic [7:0] FC_WRITE_MASK  = 8'hCF;  // bits 5 and 4 read 0
  localparam logic [7:0] FC_RESET       = 8'h00;

  // start / sync control fields
  localparam int         ST_START0      = 0;
  localparam int         ST_START1      = 1;
  localparam int         ST_SYNC        = 2;
  localparam logic [2:0] ST_RESET       = 3'h0;
  localparam logic [7:0] DF_RESET       = 8'h00;
  localparam int         STAT_CUT_BIT   = 16;

  // ******************************************************************
  // combination modes and cutoff codes
  // ******************************************************************
  typedef enum logic [1:0] {
    MODE_TIMER     = 2'b00,
    MODE_RESET_SYN = 2'b01,
    MODE_COMP_UFL  = 2'b10,
    MODE_COMP_MAT  = 2'b11
  } comb_mode_t;

  typedef enum logic [1:0] {
    CUT_OFF   = 2'b00,
    CUT_HIZ   = 2'b01,
    CUT_LOW   = 2'b10,
    CUT_HIGH  = 2'b11
  } cut_code_t;

  // pin indices; field of pin i sits at bits 7-2i and 6-2i
  localparam int PIN_A0 = 0;
  localparam int PIN_B0 = 1;
  localparam int PIN_C0 = 2;
  localparam int PIN_D0 = 3;
  localparam int NPINS  = 4;

endpackage

// ### tb/power_stage_model.sv
// Purpose: gate-driver inputs of the power stage fed by the pwm pins
// Assumes: no pull resistor on the gate-driver inputs
// Notes:   a released input wanders every cycle, so it never reads stable
`timescale 1ns/1ns

module power_stage_model (
  input  wire logic       pclk,
  input  wire logic [3:0] pin,
  input  wire logic [3:0] pin_oe,
  output logic      [3:0] seen,
  output logic      [3:0] floating
);
  logic [3:0] drift_reg = 4'h0;

  // ******************************************************************
  // levels seen by the gate drivers
  // ******************************************************************
  // an undriven input flips each cycle so a stale level cannot pass
  always @(posedge pclk) begin
    drift_reg <= ~seen;
  end

  // driven pins pass through, released ones show the wandering level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      seen[i] = pin_oe[i] ? pin[i] : drift_reg[i];
    end
    floating = ~pin_oe;
  end
endmodule

// ### tb/complementary_pwm_output_control_test.sv
// Purpose: self-checking bench for the pwm output control block
// Assumes: zero-wait apb slave, pins lag their cause by one cycle
// Notes:   drivers queue expected results, monitors pop and compare
`timescale 1ns/1ns

module complementary_pwm_output_control_test;
  logic        pclk         = 1'b0;
  logic        presetn      = 1'b0;
  logic        psel         = 1'b0;
  logic        penable      = 1'b0;
  logic        pwrite       = 1'b0;
  logic [7:0]  paddr        = 8'h00;
  logic [31:0] pwdata       = 32'h0;
  logic        cutoff_event = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  pin;
  logic [3:0]  pin_oe;
  logic [3:0]  seen;
  logic [3:0]  floating;
  logic [31:0] rdata;
  logic [33:0] rd_q[$];
  logic [7:0]  pin_q[$];
  int          miscompares  = 0;
  int          check_count  = 0;
  event        pin_tick;

  always #5 pclk = ~pclk;

  pwm_out_ctrl DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cutoff_event(cutoff_event),
    .out_pin_a0(pin[0]), .out_pin_a0_oe(pin_oe[0]),
    .out_pin_b0(pin[1]), .out_pin_b0_oe(pin_oe[1]),
    .out_pin_c0(pin[2]), .out_pin_c0_oe(pin_oe[2]),
    .out_pin_d0(pin[3]), .out_pin_d0_oe(pin_oe[3])
  );

  power_stage_model stage (
    .pclk(pclk), .pin(pin), .pin_oe(pin_oe), .seen(seen),
    .floating(floating)
  );

  // ******************************************************************
  // compare, expectation and bus tasks
  // ******************************************************************
  task automatic cmp_read(input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cmp_pins(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // expected {floating, level}; a0/c0 normal phase, b0/d0 counter phase
  function automatic logic [7:0] pin_exp(input logic [1:0] m,
    input logic [1:0] l, input logic an, input logic ac,
    input logic [7:0] cut, input logic ev);
    logic [3:0] lv;
    logic [3:0] fl;
    logic       a;
    logic [1:0] c;
    lv = 4'h0;
    fl = 4'h0;
    for (int p = 0; p < 4; p++) begin
      a = p[0] ? ac : an;
      lv[p] = (m == 2'b00) ? a : ~(a ^ l[p[0]]);
      c = cut[7-2*p -: 2];
      if (ev && c == 2'b01)
        fl[p] = 1'b1;
      else if (ev && c != 2'b00)
        lv[p] = c[0];
    end
    return {fl, lv & ~fl};
  endfunction

  // setup then access, held until pready is seen high at an edge
  task automatic apb(input logic [7:0] a, input logic w,
    input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      miscompares++;
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e,
    input logic c);
    rd_q.push_back({c, e});
    apb(a, 1'b0, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  // pins settle a few cycles after the cause, sampled mid-cycle
  task automatic pins(input logic [7:0] e);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    pin_q.push_back(e);
    -> pin_tick;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ******************************************************************
  // monitors
  // ******************************************************************
  // read data and error are taken at the completing access edge
  always @(posedge pclk) begin
    logic [33:0] rn;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      rn = rd_q.pop_front();
      if (rn[33])
        cmp_read(rn[32:0], {pslverr, prdata});
    end
  end

  always begin
    @(pin_tick);
    cmp_pins(pin_q.pop_front(), {floating, seen & ~floating});
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    miscompares++;
    report_and_stop();
  end

  // ******************************************************************
  // tests
  // ******************************************************************
  initial begin
    logic [15:0] v1;
    logic [1:0]  l;
    logic [7:0]  cut;
    void'($urandom(32'h7CA41034));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(pwm_out_pkg::OFS_FUNC_CTRL, 33'h0, 1'b1);
    rd(pwm_out_pkg::OFS_CUTOFF0, 33'h0, 1'b1);
    rd(pwm_out_pkg::OFS_START, 33'h0, 1'b1);
    rd(8'h1C, 33'h1_0000_0000, 1'b1);
    wr(pwm_out_pkg::OFS_FUNC_CTRL, 32'hFF);
    rd(pwm_out_pkg::OFS_FUNC_CTRL, {25'h0, pwm_out_pkg::FC_WRITE_MASK},
      1'b1);
    $display("test registers done");
    // every mode with every level pair, channel stopped
    for (int i = 0; i < 16; i++) begin
      wr(pwm_out_pkg::OFS_FUNC_CTRL, {28'h0, i[3:0]});
      pins(pin_exp(i[1:0], i[3:2], 1'b0, 1'b0, 8'h00, 1'b0));
    end
    $display("test levels done");
    wr(pwm_out_pkg::OFS_PERIOD, 32'h28);
    for (int i = 0; i < 4; i++) begin
      l = 2'($urandom);
      wr(pwm_out_pkg::OFS_FUNC_CTRL, {28'h0, l, 1'b0, i[1]});
      wr(pwm_out_pkg::OFS_BUFFER, i[0] ? 32'h29 : 32'h0);
      wr(pwm_out_pkg::OFS_START, 32'h1);
      pins(pin_exp({1'b0, i[1]}, l, i[0], ~i[0], 8'h0, 1'b0));
      wr(pwm_out_pkg::OFS_START, 32'h0);
      pins(pin_exp({1'b0, i[1]}, l, 1'b0, 1'b0, 8'h0, 1'b0));
    end
    $display("test running done");
    // only the counter of the other mode runs first: no transfer allowed
    for (int k = 0; k < 2; k++) begin
      v1 = 16'($urandom);
      wr(pwm_out_pkg::OFS_FUNC_CTRL, 32'h1);
      wr(pwm_out_pkg::OFS_BUFFER, {16'h0, v1});
      wr(pwm_out_pkg::OFS_FUNC_CTRL, {30'h0, 1'b1, k[0]});
      wr(pwm_out_pkg::OFS_BUFFER, {16'h0, ~v1});
      wr(pwm_out_pkg::OFS_START, k[0] ? 32'h2 : 32'h1);
      repeat (60) @(posedge pclk);
      rd(pwm_out_pkg::OFS_STATUS, {17'h0, v1}, 1'b1);
      wr(pwm_out_pkg::OFS_START, 32'h3);
      repeat (30) begin
        rd(pwm_out_pkg::OFS_STATUS, 33'h0, 1'b0);
        if (rdata[15:0] === ~v1)
          break;
      end
      rd(pwm_out_pkg::OFS_STATUS, {17'h0, ~v1}, 1'b1);
      wr(pwm_out_pkg::OFS_START, 32'h0);
    end
    $display("test transfer done");
    l = 2'($urandom);
    wr(pwm_out_pkg::OFS_FUNC_CTRL, {28'h0, l, 2'b01});
    for (int i = 0; i < 8; i++) begin
      for (int p = 0; p < 4; p++)
        cut[7-2*p -: 2] = 2'(i + p);
      wr(pwm_out_pkg::OFS_CUTOFF0, {24'h0, cut});
      rd(pwm_out_pkg::OFS_CUTOFF0, {25'h0, cut}, 1'b1);
      cutoff_event <= i[2];
      pins(pin_exp(2'b01, l, 1'b0, 1'b0, cut, i[2]));
      // status shows the cutoff request beside the duty still in force
      rd(pwm_out_pkg::OFS_STATUS, {16'h0, i[2], ~v1}, 1'b1);
    end
    cutoff_event <= 1'b0;
    $display("test cutoff done");
    report_and_stop();
  end
endmodule
